// ---- verilog/ddcpb_pkg.sv ----
/*
  package for the down-converter preset select and channel binding block:
  register indices, field positions, reset values and carrier structs.
  assumes a 32-bit APB host; every register index maps to byte address index*4.
*/
// How it works
// - in register mode, DDC B preset index comes from preset select bits 3:2.
// - in single channel operation the DDC B preset field is ignored.
// - in register mode, bits 1:0 pick DDC A frequency and phase preset n.
// - in register mode with single channel operation, the DDC A field sets the single converter NCO.
// - binding bit 1 picks ADC A (0) or ADC B (1, reset) for channel B.
// - binding bit 0 picks ADC A (0, reset) or ADC B (1) for channel A.
// - a digital channel and its link power down with its bound ADC channel.
// - divisor zero runs each NCO as a plain 32-bit phase accumulator.
// - nonzero divisor makes the accumulator wrap exactly, removing rounding error.
// - one divisor value serves every preset of both down-converters.
// - preset-source mode 0 takes both preset choices from the select fields.
// - mode 1 own pins, mode 2 channel A pins for both, mode 3 reserved.
package ddcpb_pkg;

  // register indices, byte address is index times four
  localparam logic [11:0] DDCPB_IDX_PRESET_SEL = 12'h215;
  localparam logic [11:0] DDCPB_IDX_BINDING = 12'h216;
  localparam logic [11:0] DDCPB_IDX_REF_DIV = 12'h217;
  localparam logic [11:0] DDCPB_IDX_CTRL = 12'h230;
  localparam logic [11:0] DDCPB_IDX_STATUS = 12'h231;

  // reset values
  localparam logic [7:0] DDCPB_RST_PRESET_SEL = 8'h00;
  localparam logic [7:0] DDCPB_RST_BINDING = 8'h02;
  localparam logic [15:0] DDCPB_RST_REF_DIV = 16'h0000;
  localparam logic [7:0] DDCPB_RST_CTRL = 8'h00;

  // preset select fields
  localparam int DDCPB_SEL_A_LSB = 0;
  localparam int DDCPB_SEL_B_LSB = 2;

  // binding fields
  localparam int DDCPB_BIND_A_BIT = 0;
  localparam int DDCPB_BIND_B_BIT = 1;

  // control register fields
  localparam int DDCPB_CTRL_MODE_LSB = 0;
  localparam int DDCPB_CTRL_SINGLE_BIT = 2;
  localparam int DDCPB_CTRL_PD_A_BIT = 3;
  localparam int DDCPB_CTRL_PD_B_BIT = 4;
  localparam int DDCPB_CTRL_LINK_EN_BIT = 5;
  localparam int DDCPB_CTRL_CAL_EN_BIT = 6;

  // status register fields
  localparam int DDCPB_STAT_PD_A_BIT = 0;
  localparam int DDCPB_STAT_PD_B_BIT = 1;
  localparam int DDCPB_STAT_IDX_A_LSB = 2;
  localparam int DDCPB_STAT_IDX_B_LSB = 4;
  localparam int DDCPB_STAT_DIV_ON_BIT = 6;

  // synchroniser depth for pins
  localparam int DDCPB_SYNC_STAGES = 2;

  // preset-source modes
  typedef enum logic [1:0] {
    DDCPB_MODE_REGISTER = 2'h0,
    DDCPB_MODE_OWN_PINS = 2'h1,
    DDCPB_MODE_A_PINS = 2'h2,
    DDCPB_MODE_RESERVED = 2'h3
  } ddcpb_mode_t;

  // one frequency and phase preset
  typedef struct packed {
    logic [31:0] freq;
    logic [15:0] phase;
  } ddcpb_preset_t;

  // power state of one digital channel
  typedef struct packed {
    logic channel_pd;
    logic link_pd;
  } ddcpb_power_t;

endpackage

// ---- verilog/ddcpb_sync.sv ----
/*
  two-flop synchroniser for a bus of independent levels.
  assumes each bit is a slow level; no relation between bits is kept.
*/
`timescale 1ns/10ps
module ddcpb_sync
  import ddcpb_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_one <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule

// ---- verilog/ddcpb_nco.sv ----
/*
  phase accumulator of one down-converter with optional reference divisor.
  assumes frequency, phase and divisor are steady levels on ref_clk.
*/
`timescale 1ns/10ps
module ddcpb_nco
  import ddcpb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // configuration
  input wire logic run,
  input wire ddcpb_preset_t preset,
  input wire logic [15:0] ref_div,
  // output
  output logic [31:0] accum,
  output logic [15:0] phase_out
);

  logic [32:0] sum;
  logic [32:0] modulus;
  logic [31:0] next_accum;

  // wrap point is divisor times 2^16 when the divisor is used
  always_comb begin
    sum = {1'b0, accum} + {1'b0, preset.freq};
    modulus = {1'b0, ref_div, 16'h0000};
    if (ref_div == 16'h0000) begin
      next_accum = sum[31:0];
    end else if (sum >= modulus) begin
      next_accum = 32'(sum - modulus);
    end else begin
      next_accum = sum[31:0];
    end
  end

  // accumulator holds at zero while its channel is down
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      accum <= 32'h00000000;
    end else if (clk_en) begin
      if (!run) begin
        accum <= 32'h00000000;
      end else begin
        accum <= next_accum;
      end
    end
  end

  // phase output with preset offset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_out <= 16'h0000;
    end else if (clk_en) begin
      phase_out <= accum[31:16] + preset.phase;
    end
  end

endmodule

// ---- verilog/ddcpb_top.sv ----
/*
  preset select, channel binding and reference divisor registers of the
  dual down-converter path, with the two NCO accumulators they steer.
  assumes an APB master on ref_clk, preset values from elsewhere on ref_clk,
  and preset pins arriving asynchronously.
*/
`timescale 1ns/10ps
module ddcpb_top
  import ddcpb_pkg::*;
(
  // clock, enable and reset
  input wire logic ref_clk,
  input wire logic clk_en,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // preset pins
  input wire logic [1:0] chan_a_preset_pins,
  input wire logic [1:0] chan_b_preset_pins,
  // preset values
  input wire ddcpb_preset_t [3:0] chan_a_presets,
  input wire ddcpb_preset_t [3:0] chan_b_presets,
  // selected presets
  output logic [1:0] ddc_a_active_idx,
  output logic [1:0] ddc_b_active_idx,
  output ddcpb_preset_t ddc_a_active,
  output ddcpb_preset_t ddc_b_active,
  // nco outputs
  output logic [15:0] ddc_a_phase,
  output logic [15:0] ddc_b_phase,
  // channel binding and power
  output logic chan_a_from_adc_b,
  output logic chan_b_from_adc_b,
  output ddcpb_power_t chan_a_power,
  output ddcpb_power_t chan_b_power,
  // control levels
  output logic serial_link_enable,
  output logic cal_enable,
  output logic single_channel
);

  // reset release
  logic rst_meta_n;
  logic rst_sync_n;

  // registers
  logic [7:0] preset_select;
  logic [7:0] channel_binding;
  logic [15:0] reference_divisor;
  logic [7:0] control;

  // decode and bus
  logic setup_phase;
  logic access_phase;
  logic addr_aligned;
  logic [11:0] reg_index;
  logic hit_sel;
  logic hit_bind;
  logic hit_div;
  logic hit_ctrl;
  logic hit_stat;
  logic mapped;
  logic [31:0] read_mux;
  logic [31:0] status_word;
  logic [31:0] strb_mask;

  // selection
  logic [1:0] pins_a;
  logic [1:0] pins_b;
  ddcpb_mode_t preset_source_mode;
  logic [1:0] ddc_a_preset_field;
  logic [1:0] ddc_b_preset_field;
  logic [1:0] next_idx_a;
  logic [1:0] next_idx_b;
  logic adc_a_power_down;
  logic adc_b_power_down;
  logic next_pd_a;
  logic next_pd_b;
  ddcpb_preset_t [1:0] nco_cfg;
  logic [1:0] nco_run;
  logic [1:0][15:0] nco_phase;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // preset pins cross into ref_clk
  ddcpb_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_sync_n),
    .clk_en(clk_en),
    .async_in({chan_b_preset_pins, chan_a_preset_pins}),
    .sync_out({pins_b, pins_a})
  );

  // apb phase and address decode
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign addr_aligned = (paddr[1:0] == 2'h0);
  assign reg_index = {2'h0, paddr[11:2]};

  always_comb begin
    hit_sel = 1'b0;
    hit_bind = 1'b0;
    hit_div = 1'b0;
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    if (!addr_aligned) begin
      hit_sel = 1'b0;
    end else if (reg_index == DDCPB_IDX_PRESET_SEL) begin
      hit_sel = 1'b1;
    end else if (reg_index == DDCPB_IDX_BINDING) begin
      hit_bind = 1'b1;
    end else if (reg_index == DDCPB_IDX_REF_DIV) begin
      hit_div = 1'b1;
    end else if (reg_index == DDCPB_IDX_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (reg_index == DDCPB_IDX_STATUS) begin
      hit_stat = 1'b1;
    end
  end

  assign mapped = hit_sel || hit_bind || hit_div || hit_ctrl || hit_stat;
  // zero wait states; error on unmapped or read-only write
  assign pready = access_phase;
  assign pslverr = access_phase && (!mapped || (pwrite && hit_stat));

  // byte enables to bit mask
  always_comb begin
    strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  end

  // preset select register, reserved bits kept
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      preset_select <= DDCPB_RST_PRESET_SEL;
    end else if (clk_en) begin
      if (access_phase && pwrite && hit_sel) begin
        preset_select <= (preset_select & ~strb_mask[7:0]) | (pwdata[7:0] & strb_mask[7:0]);
      end
    end
  end

  // channel binding register, reserved bits kept
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      channel_binding <= DDCPB_RST_BINDING;
    end else if (clk_en) begin
      if (access_phase && pwrite && hit_bind) begin
        channel_binding <= (channel_binding & ~strb_mask[7:0]) | (pwdata[7:0] & strb_mask[7:0]);
      end
    end
  end

  // reference divisor, shared by all presets
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reference_divisor <= DDCPB_RST_REF_DIV;
    end else if (clk_en) begin
      if (access_phase && pwrite && hit_div) begin
        reference_divisor <= (reference_divisor & ~strb_mask[15:0]) |
                             (pwdata[15:0] & strb_mask[15:0]);
      end
    end
  end

  // control register: mode, single channel, power-downs, enables
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      control <= DDCPB_RST_CTRL;
    end else if (clk_en) begin
      if (access_phase && pwrite && hit_ctrl) begin
        control <= (control & ~strb_mask[7:0]) | (pwdata[7:0] & strb_mask[7:0]);
      end
    end
  end

  // control fields
  assign preset_source_mode = ddcpb_mode_t'(control[DDCPB_CTRL_MODE_LSB +: 2]);
  assign single_channel = control[DDCPB_CTRL_SINGLE_BIT];
  assign adc_a_power_down = control[DDCPB_CTRL_PD_A_BIT];
  assign adc_b_power_down = control[DDCPB_CTRL_PD_B_BIT];
  assign serial_link_enable = control[DDCPB_CTRL_LINK_EN_BIT];
  assign cal_enable = control[DDCPB_CTRL_CAL_EN_BIT];
  assign ddc_a_preset_field = preset_select[DDCPB_SEL_A_LSB +: 2];
  assign ddc_b_preset_field = preset_select[DDCPB_SEL_B_LSB +: 2];

  // status word shows the block's own state
  always_comb begin
    status_word = 32'h00000000;
    status_word[DDCPB_STAT_PD_A_BIT] = chan_a_power.channel_pd;
    status_word[DDCPB_STAT_PD_B_BIT] = chan_b_power.channel_pd;
    status_word[DDCPB_STAT_IDX_A_LSB +: 2] = ddc_a_active_idx;
    status_word[DDCPB_STAT_IDX_B_LSB +: 2] = ddc_b_active_idx;
    status_word[DDCPB_STAT_DIV_ON_BIT] = (reference_divisor != 16'h0000);
  end

  // read mux, narrow registers in low bits
  always_comb begin
    read_mux = 32'h00000000;
    if (hit_sel) begin
      read_mux = {24'h000000, preset_select};
    end else if (hit_bind) begin
      read_mux = {24'h000000, channel_binding};
    end else if (hit_div) begin
      read_mux = {16'h0000, reference_divisor};
    end else if (hit_ctrl) begin
      read_mux = {24'h000000, control};
    end else if (hit_stat) begin
      read_mux = status_word;
    end
  end

  // read data captured in the setup cycle, held through access
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata <= 32'h00000000;
    end else if (clk_en) begin
      if (setup_phase && !pwrite) begin
        prdata <= read_mux;
      end
    end
  end

  // preset index selection per source mode
  always_comb begin
    next_idx_a = ddc_a_preset_field;
    next_idx_b = ddc_b_preset_field;
    case (preset_source_mode)
      DDCPB_MODE_REGISTER: begin
        next_idx_a = ddc_a_preset_field;
        next_idx_b = ddc_b_preset_field;
      end
      DDCPB_MODE_OWN_PINS: begin
        next_idx_a = pins_a;
        next_idx_b = pins_b;
      end
      DDCPB_MODE_A_PINS: begin
        next_idx_a = pins_a;
        next_idx_b = pins_a;
      end
      default: begin
        next_idx_a = ddc_a_preset_field;
        next_idx_b = ddc_b_preset_field;
      end
    endcase
    if (single_channel) begin
      next_idx_b = next_idx_a;
    end
  end

  // active index and preset registers
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ddc_a_active_idx <= 2'h0;
      ddc_b_active_idx <= 2'h0;
      ddc_a_active <= '0;
      ddc_b_active <= '0;
    end else if (clk_en) begin
      ddc_a_active_idx <= next_idx_a;
      ddc_b_active_idx <= next_idx_b;
      ddc_a_active <= chan_a_presets[next_idx_a];
      if (single_channel) begin
        ddc_b_active <= chan_a_presets[next_idx_a];
      end else begin
        ddc_b_active <= chan_b_presets[next_idx_b];
      end
    end
  end

  // bound adc source per digital channel
  assign next_pd_a = channel_binding[DDCPB_BIND_A_BIT] ? adc_b_power_down : adc_a_power_down;
  assign next_pd_b = channel_binding[DDCPB_BIND_B_BIT] ? adc_b_power_down : adc_a_power_down;

  // binding and power-down outputs
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      chan_a_from_adc_b <= 1'b0;
      chan_b_from_adc_b <= 1'b1;
      chan_a_power <= '0;
      chan_b_power <= '0;
    end else if (clk_en) begin
      chan_a_from_adc_b <= channel_binding[DDCPB_BIND_A_BIT];
      chan_b_from_adc_b <= channel_binding[DDCPB_BIND_B_BIT];
      chan_a_power <= '{channel_pd: next_pd_a, link_pd: next_pd_a};
      chan_b_power <= '{channel_pd: next_pd_b, link_pd: next_pd_b};
    end
  end

  // nco inputs per down-converter
  assign nco_cfg[0] = ddc_a_active;
  assign nco_cfg[1] = ddc_b_active;
  assign nco_run[0] = !chan_a_power.channel_pd;
  assign nco_run[1] = !chan_b_power.channel_pd;

  // one accumulator per down-converter, shared divisor
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_nco
      ddcpb_nco u_nco (
        .ref_clk(ref_clk),
        .rst_n(rst_sync_n),
        .clk_en(clk_en),
        .run(nco_run[gi]),
        .preset(nco_cfg[gi]),
        .ref_div(reference_divisor),
        .accum(),
        .phase_out(nco_phase[gi])
      );
    end
  endgenerate

  assign ddc_a_phase = nco_phase[0];
  assign ddc_b_phase = nco_phase[1];

endmodule

// ---- verif/ddcpb_top_sva.sv ----
/*
  checker for the preset select and binding block: bus timing, binding
  follow-through, power pairing and single channel mirroring.
  assumes it is bound to ddcpb_top and sees only its ports.
*/
`timescale 1ns/10ps
module ddcpb_top_sva
  import ddcpb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // observed outputs
  input wire logic [1:0] ddc_a_active_idx,
  input wire logic [1:0] ddc_b_active_idx,
  input wire ddcpb_preset_t ddc_a_active,
  input wire ddcpb_preset_t ddc_b_active,
  input wire logic chan_a_from_adc_b,
  input wire logic chan_b_from_adc_b,
  input wire ddcpb_power_t chan_a_power,
  input wire ddcpb_power_t chan_b_power,
  input wire logic single_channel
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // bus phases and a stored binding write
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_bind_wr;
    s_access ##0 (pwrite && clk_en && paddr == 12'h858 && pstrb[0]);
  endsequence
  sequence s_single_held;
    single_channel && $past(single_channel) && $past(single_channel, 2);
  endsequence

  a_pready_zero_wait: assert property (s_access |-> pready)
    else $error("pready missing in access phase");
  a_slverr_unmapped: assert property (s_access ##0 !(paddr inside
    {12'h854, 12'h858, 12'h85C, 12'h8C0, 12'h8C4}) |-> pslverr)
    else $error("unmapped access not refused");
  a_idle_quiet: assert property (!psel |-> !pready && !pslverr)
    else $error("bus answer outside a transfer");
  a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");
  a_bind_a_follow: assert property (
    s_bind_wr |-> ##2 chan_a_from_adc_b == $past(pwdata[0], 2))
    else $error("channel a source not taken from binding");
  a_bind_b_follow: assert property (
    s_bind_wr |-> ##2 chan_b_from_adc_b == $past(pwdata[1], 2))
    else $error("channel b source not taken from binding");
  a_power_pair: assert property (
    chan_a_power.channel_pd == chan_a_power.link_pd &&
    chan_b_power.channel_pd == chan_b_power.link_pd)
    else $error("channel and link power split");
  a_single_idx_mirror: assert property (
    s_single_held |-> ddc_b_active_idx == ddc_a_active_idx)
    else $error("single channel index not mirrored");
  a_single_preset_mirror: assert property (
    s_single_held |-> ddc_b_active == ddc_a_active)
    else $error("single channel preset not mirrored");
endmodule

bind ddcpb_top ddcpb_top_sva ddcpb_top_sva_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ddc_a_active_idx(ddc_a_active_idx),
  .ddc_b_active_idx(ddc_b_active_idx), .ddc_a_active(ddc_a_active),
  .ddc_b_active(ddc_b_active), .chan_a_from_adc_b(chan_a_from_adc_b),
  .chan_b_from_adc_b(chan_b_from_adc_b), .chan_a_power(chan_a_power),
  .chan_b_power(chan_b_power), .single_channel(single_channel)
);

// ---- verif/ddcpb_top_bench.sv ----
/*
  self-checking bench for the preset select and binding block.
  assumes the zero-wait apb slave and the register map of the package.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_count++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module ddcpb_top_bench
  import ddcpb_pkg::*;
;
  logic ref_clk = 1'b0;
  logic clk_en, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [1:0] pins_a, pins_b, idx_a, idx_b;
  ddcpb_preset_t [3:0] pre_a, pre_b;
  ddcpb_preset_t act_a, act_b;
  logic [15:0] ph_a, ph_b;
  logic from_a, from_b, link_en, cal_en, single;
  ddcpb_power_t pw_a, pw_b;
  int err_count, n_checks, m_sel, m_bind, m_ctrl, m_div;

  ddcpb_top ddcpb_top_inst (
    .ref_clk(ref_clk), .clk_en(clk_en), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_a_preset_pins(pins_a),
    .chan_b_preset_pins(pins_b), .chan_a_presets(pre_a), .chan_b_presets(pre_b),
    .ddc_a_active_idx(idx_a), .ddc_b_active_idx(idx_b), .ddc_a_active(act_a),
    .ddc_b_active(act_b), .ddc_a_phase(ph_a), .ddc_b_phase(ph_b),
    .chan_a_from_adc_b(from_a), .chan_b_from_adc_b(from_b), .chan_a_power(pw_a),
    .chan_b_power(pw_b), .serial_link_enable(link_en), .cal_enable(cal_en),
    .single_channel(single)
  );

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // one apb transfer, entered right after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never answers
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [11:0] a, input int d);
    apb(1'b1, a, d);
    `CHK("wr_err", 1'b0, e)
  endtask

  task automatic rdchk(input logic [11:0] a, input int ex, input logic er);
    apb(1'b0, a, 32'h0);
    `CHK("rd_err", er, e)
    `CHK("rd_data", ex, rd)
  endtask

  // model of selection, binding and power from the shadow registers
  task automatic check_out();
    int md, ia, ib, pda, pdb, sg;
    md = m_ctrl & 3;
    sg = (m_ctrl >> 2) & 1;
    ia = (md == 1 || md == 2) ? int'(pins_a) : m_sel & 3;
    ib = (md == 1) ? int'(pins_b) : (md == 2) ? int'(pins_a) : (m_sel >> 2) & 3;
    if (sg == 1) ib = ia;
    pda = ((m_bind & 1) ? m_ctrl >> 4 : m_ctrl >> 3) & 1;
    pdb = ((m_bind & 2) ? m_ctrl >> 4 : m_ctrl >> 3) & 1;
    `CHK("idx_a", ia, idx_a)
    `CHK("idx_b", ib, idx_b)
    `CHK("act_a", pre_a[ia], act_a)
    `CHK("act_b", sg ? pre_a[ia] : pre_b[ib], act_b)
    `CHK("from_a", m_bind & 1, from_a)
    `CHK("from_b", (m_bind >> 1) & 1, from_b)
    `CHK("pw_a", {pda[0], pda[0]}, pw_a)
    `CHK("pw_b", {pdb[0], pdb[0]}, pw_b)
    `CHK("link", (m_ctrl >> 5) & 1, link_en)
    `CHK("cal", (m_ctrl >> 6) & 1, cal_en)
    `CHK("single", sg, single)
    apb(1'b0, 12'h8C4, 32'h0);
    `CHK("status", ((m_div != 0) << 6) | (ib << 4) | (ia << 2) | (pdb << 1) | pda, rd[6:0])
  endtask

  // accumulators restart from zero, then step once per edge
  task automatic nco_run(input int d, input int p);
    int a0, k, ex;
    wr(12'h8C0, 32'h18); // both adc powered down
    m_ctrl = 32'h18;
    pre_a[0] <= {32'h0001_0000, 16'(p)};
    pre_b[0] <= {32'h0001_0000, 16'(p)};
    wr(12'h854, 0);
    m_sel = 0;
    wr(12'h85C, d);
    m_div = d;
    rdchk(12'h85C, d, 1'b0);
    wr(12'h8C0, 0);
    m_ctrl = 0;
    repeat (3) @(posedge ref_clk);
    a0 = (int'(ph_a) - p) & 16'hFFFF;
    if (d != 0) `CHK("anchor", 1'b1, a0 < d)
    for (k = 1; k <= 12; k++) begin
      @(posedge ref_clk);
      ex = (((a0 + k) % (d == 0 ? 65536 : d)) + p) & 16'hFFFF;
      `CHK("phase_a", 16'(ex), ph_a)
      `CHK("phase_b", 16'(ex), ph_b)
    end
    // frozen clock enable holds the phase
    clk_en <= 1'b0;
    ex = (((a0 + 13) % (d == 0 ? 65536 : d)) + p) & 16'hFFFF;
    repeat (3) @(posedge ref_clk);
    `CHK("freeze", 16'(ex), ph_a)
    clk_en <= 1'b1;
    check_out();
  endtask

  // verdict
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    $display("wrong value watchdog exp done got hang");
    tally_and_finish();
  end

  // main sequence
  initial begin
    int i, k, c, b, s;
    clk_en = 1'b1;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    pins_a = 2'h0;
    pins_b = 2'h0;
    pre_a = '0;
    pre_b = '0;
    err_count = 0;
    n_checks = 0;
    m_sel = 0;
    m_bind = 2;
    m_ctrl = 0;
    m_div = 0;
    void'($urandom(32'h0ff7b903));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // reset values and refusals
    rdchk(12'h854, 0, 1'b0);
    rdchk(12'h858, 2, 1'b0);
    rdchk(12'h85C, 0, 1'b0);
    rdchk(12'h8C0, 0, 1'b0);
    // byte strobes: only lane 1 of the divisor is written
    pstrb <= 4'h2;
    wr(12'h85C, 32'h0000ABCD);
    pstrb <= 4'hF;
    rdchk(12'h85C, 32'h0000AB00, 1'b0);
    wr(12'h85C, 0);
    rdchk(12'h000, 0, 1'b1);
    rdchk(12'h855, 0, 1'b1);
    apb(1'b1, 12'h8C4, 32'hFF);
    `CHK("status_wr_err", 1'b1, e)
    check_out();
    // random modes, bindings, selections and pins
    for (i = 0; i < 40; i++) begin
      for (k = 0; k < 4; k++) begin
        pre_a[k] <= {$urandom, 16'($urandom)};
        pre_b[k] <= {$urandom, 16'($urandom)};
      end
      pins_a <= 2'($urandom);
      pins_b <= 2'($urandom);
      c = $urandom & 8'h9F;
      b = (c & 4) ? 2 : $urandom & 255;
      wr(12'h8C0, c & 8'h9B);
      m_ctrl = c & 8'h9B;
      wr(12'h858, b);
      m_bind = b;
      s = $urandom & 255;
      wr(12'h854, s);
      m_sel = s;
      c = c | ($urandom & 8'h60);
      wr(12'h8C0, c);
      m_ctrl = c;
      repeat (4) @(posedge ref_clk);
      check_out();
      rdchk(12'h854, m_sel, 1'b0);
      rdchk(12'h858, m_bind, 1'b0);
      rdchk(12'h8C0, m_ctrl, 1'b0);
    end
    // divisor off, then exact wraps with integer divisors
    m_ctrl = m_ctrl & 8'h9F;
    wr(12'h8C0, m_ctrl);
    wr(12'h858, 2);
    m_bind = 2;
    nco_run(0, 16'h1234);
    nco_run(5, int'(16'($urandom)));
    nco_run(3, 16'hFFFE);
    tally_and_finish();
  end
endmodule
